/* spms_params.svh */
// constants of the spi master/slave port: register indexes, widths, counts, reset values
`ifndef SPMS_PARAMS_SVH
`define SPMS_PARAMS_SVH

// register indexes; byte address is four times the index
`define SPMS_IDX_CTRL     8'hc3
`define SPMS_IDX_STATUS   8'hc4
`define SPMS_IDX_DATA     8'hc5
`define SPMS_IDX_IEN      8'hc6
`define SPMS_IDX_ICLR     8'hc7
`define SPMS_IDX_LSB      2

// field layout
`define SPMS_BYTE_MSB     7
`define SPMS_FLAG_LSB     4
`define SPMS_PAD_RD       24'h00_0000
`define SPMS_RSVD_RD      4'h0

// sequencing counts
`define SPMS_EDGE_LAST    4'hf
`define SPMS_CAP_LAST     3'h7
`define SPMS_RATE_NONE    3'h7
`define SPMS_DIV_W        7

// reset values
`define SPMS_CTRL_RST     8'h00
`define SPMS_BYTE_RST     8'h00
`define SPMS_FLAGS_RST    4'h0
`define SPMS_WORD_RST     32'h0000_0000
`define SPMS_READY_RST    1'b1
`define SPMS_OKAY         1'b0

`endif

/* spms_pkg.sv */
// types of the spi master/slave port
package spms_pkg;
  typedef struct packed {
    logic rate_sel_bit2;
    logic spi_enable;
    logic ss_disable;
    logic master_select;
    logic cpol;
    logic cpha;
    logic rate_sel_bit1;
    logic rate_sel_bit0;
  } spms_ctrl_t;

  typedef struct packed {
    logic xfer_done;
    logic overflow;
    logic slave_error_flag;
    logic mode_fault_flag;
  } spms_flags_t;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } spms_pins_t;

  typedef enum logic {SPMS_IDLE, SPMS_RUN} spms_state_t;
endpackage

/* spms_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module spms_sync #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         ce,
  // data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_reg;

  // pins idle high through reset so ss_n does not look asserted
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= '1;
      dout     <= '1;
    end else if (ce) begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule

/* spms_clkdiv.sv */
// master baud divider: one tick per half serial clock period
`timescale 1ns/10ps
`include "spms_params.svh"
module spms_clkdiv #(
  parameter int DIV_W = `SPMS_DIV_W
) (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       ce,
  // control
  input  wire logic       run,
  input  wire logic [2:0] rate_sel,
  // half-period pulse
  output logic            tick
);
  logic [DIV_W-1:0] cnt_reg;

  // half period is 2^rate_sel cycles, so the full divisor runs 2..128
  wire logic [DIV_W-1:0] limit  = DIV_W'((1 << rate_sel) - 1);
  wire logic             no_brg = (rate_sel == `SPMS_RATE_NONE);
  wire logic             hit    = (cnt_reg == limit);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else if (ce) begin
      cnt_reg <= (!run || no_brg || hit) ? '0 : cnt_reg + 1'b1;
      tick    <= run && !no_brg && hit;
    end
  end
endmodule

/* spms_top.sv */
// spi master/slave port: ahb-lite registers, shift engine, fault flags, interrupt
`timescale 1ns/10ps
`include "spms_params.svh"
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - eight serial clocks exchange one byte
// - slave miso floats while select is high unless cpha and ss_disable are set
// - mode fault sets on wrong select level
// - master with ss_disable ignores select
// - slave with cpha and ss_disable always selected
// - clearing ss_disable keeps mode fault
// - cpha zero slave starts on select
// - master clock divides by 2 to 128
// - select lost mid-byte sets slave error
// - data write loads shift register directly
// - data read returns receive buffer
// - data write during transfer is overflow
// - clearing spi_enable stops port at once
// - registers accessible while idle
// - reserved status bits read as don't-care
////////////////////////////////////////////////////////////////////////////////
module spms_top #(
  parameter int DIV_W = `SPMS_DIV_W
) (
  // clock, reset, enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // serial clock pin
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe_n,
  // master-out pin
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe_n,
  // master-in pin
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe_n,
  // slave select pin
  input  wire logic        ss_n_in,
  // interrupt
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  spms_pkg::spms_pins_t  pins_raw;
  spms_pkg::spms_pins_t  pins_s;
  spms_pkg::spms_ctrl_t  ctrl_reg;
  spms_pkg::spms_flags_t flags_reg;
  spms_pkg::spms_flags_t flags_next;
  spms_pkg::spms_flags_t ien_reg;
  spms_pkg::spms_state_t state_reg;
  spms_pkg::spms_state_t state_next;
  logic [7:0]            shreg_reg;
  logic [7:0]            rx_buf_reg;
  logic [3:0]            edge_cnt_reg;
  logic [2:0]            cap_cnt_reg;
  logic                  out_bit_reg;
  logic                  sck_d_reg;
  logic                  sel_d_reg;
  logic                  dp_valid_reg;
  logic                  dp_write_reg;
  logic [31:0]           dp_addr_reg;
  logic                  tick;

  // hsize is single-word only; accepted and not decoded
  wire logic unused_size = |hsize;

  function automatic logic spms_hit(input logic [31:0] a, input logic [7:0] idx);
    spms_hit = (a == (32'(idx) << `SPMS_IDX_LSB));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin inputs through two flops
  assign pins_raw = '{sck: sck_in, mosi: mosi_in, miso: miso_in, ss_n: ss_n_in};

  spms_sync #(
    .W ($bits(spms_pkg::spms_pins_t))
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .din     (pins_raw),
    .dout    (pins_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // role and select decoding
  wire logic       en        = ctrl_reg.spi_enable;
  wire logic       cpha      = ctrl_reg.cpha;
  wire logic       cpol      = ctrl_reg.cpol;
  wire logic [2:0] rate_sel  = {ctrl_reg.rate_sel_bit2, ctrl_reg.rate_sel_bit1,
                                ctrl_reg.rate_sel_bit0};
  wire logic       is_master = en & ctrl_reg.master_select;
  wire logic       is_slave  = en & ~ctrl_reg.master_select;
  wire logic       ss_low    = ~pins_s.ss_n;
  wire logic       always_sel = cpha & ctrl_reg.ss_disable;
  wire logic       slave_sel = is_slave & (ss_low | always_sel);
  wire logic       mode_fault_flag_cond = is_master & ~ctrl_reg.ss_disable & ss_low;
  wire logic       ss_ok_m   = is_master & pins_s.ss_n;
  wire logic       master_ok = is_master & ~flags_reg.mode_fault_flag;
  wire logic       m_run     = (state_reg == spms_pkg::SPMS_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite decode
  wire logic addr_ph  = hsel & hready & htrans[1];
  wire logic wr       = dp_valid_reg & dp_write_reg;
  wire logic wr_ctrl  = wr & spms_hit(dp_addr_reg, `SPMS_IDX_CTRL);
  wire logic wr_data  = wr & spms_hit(dp_addr_reg, `SPMS_IDX_DATA);
  wire logic wr_ien   = wr & spms_hit(dp_addr_reg, `SPMS_IDX_IEN);
  wire logic wr_iclr  = wr & spms_hit(dp_addr_reg, `SPMS_IDX_ICLR);
  wire logic [7:0] wdata = hwdata[`SPMS_BYTE_MSB:0];

  // status low nibble is don't-care; it reads as zero here
  wire logic [7:0] status_rd = {flags_reg, `SPMS_RSVD_RD};
  wire logic [7:0] ien_rd    = {ien_reg, `SPMS_RSVD_RD};

  // the data register returns the receive buffer, never the shifter
  wire logic [7:0] rd_byte =
      spms_hit(haddr, `SPMS_IDX_CTRL)   ? ctrl_reg   :
      spms_hit(haddr, `SPMS_IDX_STATUS) ? status_rd  :
      spms_hit(haddr, `SPMS_IDX_DATA)   ? rx_buf_reg :
      spms_hit(haddr, `SPMS_IDX_IEN)    ? ien_rd     : `SPMS_BYTE_RST;
  wire logic [31:0] rd_next = (addr_ph & ~hwrite) ? {`SPMS_PAD_RD, rd_byte}
                                                  : `SPMS_WORD_RST;

  wire spms_pkg::spms_flags_t clr =
      wr_iclr ? spms_pkg::spms_flags_t'(wdata[`SPMS_BYTE_MSB:`SPMS_FLAG_LSB])
              : spms_pkg::spms_flags_t'(`SPMS_FLAGS_RST);

  ////////////////////////////////////////////////////////////////////////////
  // master baud generator
  spms_clkdiv #(
    .DIV_W (DIV_W)
  ) u_div (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ce       (ce),
    .run      (m_run & master_ok),
    .rate_sel (rate_sel),
    .tick     (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // edge selection
  // master: even edge counts are leading edges; cpha picks which one samples
  wire logic m_tick   = tick & m_run & master_ok;
  wire logic m_cap    = m_tick & (edge_cnt_reg[0] == cpha);
  wire logic m_launch = m_tick & (edge_cnt_reg[0] != cpha);
  wire logic m_end    = m_tick & (edge_cnt_reg == `SPMS_EDGE_LAST);

  // slave: edges of the synchronised clock; leading means leaving cpol
  wire logic sck_chg  = pins_s.sck ^ sck_d_reg;
  wire logic s_lead   = slave_sel & sck_chg & (pins_s.sck != cpol);
  wire logic s_trail  = slave_sel & sck_chg & (pins_s.sck == cpol);
  wire logic s_cap    = cpha ? s_trail : s_lead;
  wire logic s_launch = cpha ? s_lead : s_trail;
  wire logic sel_rise = slave_sel & ~sel_d_reg;

  wire logic capture  = m_cap | s_cap;
  wire logic launch   = m_launch | s_launch;
  wire logic in_bit   = is_master ? pins_s.miso : pins_s.mosi;
  wire logic [7:0] cap_byte = {shreg_reg[6:0], in_bit};
  wire logic byte_done = capture & (cap_cnt_reg == `SPMS_CAP_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // transfer control
  wire logic active   = m_run | slave_sel;
  wire logic busy     = m_run | (slave_sel & (cap_cnt_reg != '0));
  wire logic load     = wr_data & ~busy;
  wire logic ovf_set  = wr_data & busy;
  wire logic start_m  = load & master_ok;
  // slave error: select gone with part of a byte shifted in
  wire logic serr_set = is_slave & sel_d_reg & ~slave_sel &
                        (cap_cnt_reg != '0);

  // losing enable, role or select fault abandons the byte at once
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      spms_pkg::SPMS_IDLE: begin
        if (start_m) begin
          state_next = spms_pkg::SPMS_RUN;
        end
      end
      spms_pkg::SPMS_RUN: begin
        if (!master_ok || m_end) begin
          state_next = spms_pkg::SPMS_IDLE;
        end
      end
    endcase
  end

  wire logic [3:0] edge_next = !m_run ? '0 : (m_tick ? edge_cnt_reg + 1'b1 : edge_cnt_reg);
  wire logic [2:0] cap_next  = (!active || start_m) ? '0 :
                               (capture ? cap_cnt_reg + 1'b1 : cap_cnt_reg);
  wire logic [7:0] sh_next   = load ? wdata : (capture ? cap_byte : shreg_reg);
  // cpha zero shows bit 7 before the first edge: on load or on select
  wire logic       out_next  = (load & ~cpha) ? wdata[`SPMS_BYTE_MSB] :
                               (launch | (sel_rise & ~cpha)) ? shreg_reg[`SPMS_BYTE_MSB] :
                               out_bit_reg;
  wire logic [7:0] rx_next   = byte_done ? cap_byte : rx_buf_reg;
  wire logic       sck_next  = !m_run ? cpol :
                               (m_tick ? ~sck_out : sck_out);

  ////////////////////////////////////////////////////////////////////////////
  // flags: hardware set wins over a software clear
  assign flags_next.xfer_done = byte_done | (flags_reg.xfer_done & ~clr.xfer_done);
  assign flags_next.overflow  = ovf_set | (flags_reg.overflow & ~clr.overflow);
  // slave error ignores the clear register; only dropping enable clears it
  assign flags_next.slave_error_flag = en & (serr_set | flags_reg.slave_error_flag);
  // ss_disable takes no part in clearing, so dropping it keeps the fault
  assign flags_next.mode_fault_flag = mode_fault_flag_cond |
      (flags_reg.mode_fault_flag & ~clr.mode_fault_flag & ~ss_ok_m);

  ////////////////////////////////////////////////////////////////////////////
  // bus registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= `SPMS_WORD_RST;
      hrdata       <= `SPMS_WORD_RST;
      hreadyout    <= `SPMS_READY_RST;
      hresp        <= `SPMS_OKAY;
    end else if (ce) begin
      dp_valid_reg <= addr_ph;
      dp_write_reg <= hwrite;
      dp_addr_reg  <= haddr;
      hrdata       <= rd_next;
      hreadyout    <= `SPMS_READY_RST;
      hresp        <= `SPMS_OKAY;
    end
  end

  // control register; software keeps mode bits still mid-transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= spms_pkg::spms_ctrl_t'(`SPMS_CTRL_RST);
      ien_reg  <= spms_pkg::spms_flags_t'(`SPMS_FLAGS_RST);
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_reg <= spms_pkg::spms_ctrl_t'(wdata);
      end
      if (wr_ien) begin
        ien_reg <= spms_pkg::spms_flags_t'(wdata[`SPMS_BYTE_MSB:`SPMS_FLAG_LSB]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift engine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg    <= spms_pkg::SPMS_IDLE;
      edge_cnt_reg <= '0;
      cap_cnt_reg  <= '0;
      shreg_reg    <= `SPMS_BYTE_RST;
      rx_buf_reg   <= `SPMS_BYTE_RST;
      out_bit_reg  <= 1'b0;
      sck_d_reg    <= 1'b0;
      sel_d_reg    <= 1'b0;
    end else if (ce) begin
      state_reg    <= state_next;
      edge_cnt_reg <= edge_next;
      cap_cnt_reg  <= cap_next;
      shreg_reg    <= sh_next;
      rx_buf_reg   <= rx_next;
      out_bit_reg  <= out_next;
      sck_d_reg    <= pins_s.sck;
      sel_d_reg    <= slave_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers and interrupt, all from flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_reg <= spms_pkg::spms_flags_t'(`SPMS_FLAGS_RST);
      sck_out   <= 1'b0;
      sck_oe_n  <= 1'b1;
      mosi_oe_n <= 1'b1;
      miso_oe_n <= 1'b1;
      irq       <= 1'b0;
    end else if (ce) begin
      flags_reg <= flags_next;
      sck_out   <= sck_next;
      // a faulted or disabled master lets go of clock and data at once
      sck_oe_n  <= ~master_ok;
      mosi_oe_n <= ~master_ok;
      miso_oe_n <= ~slave_sel;
      irq       <= |(flags_next & ien_reg);
    end
  end

  // one data flop feeds both data pins; only the enables differ
  assign mosi_out = out_bit_reg;
  assign miso_out = out_bit_reg;

endmodule

/* spms_top_assertions.sv */
// concurrent checks on the spi port's bus answers and pin enables
`timescale 1ns/10ps
`include "spms_params.svh"
module spms_top_assertions #(
  parameter int DIV_W = `SPMS_DIV_W
) (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // pins and interrupt
  input wire logic        sck_oe_n,
  input wire logic        mosi_oe_n,
  input wire logic        miso_oe_n,
  input wire logic        irq
);
  localparam logic [31:0] A_STAT = {22'h0, `SPMS_IDX_STATUS, 2'h0};
  localparam logic [31:0] A_ICLR = {22'h0, `SPMS_IDX_ICLR, 2'h0};
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////
  sequence s_any_rd;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence s_rd(logic [31:0] a);
    hsel && hready && htrans[1] && !hwrite && haddr == a;
  endsequence
  ////////////////////////////////////////
  a_ready_okay: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or gave an error");
  a_rdata_cause: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0)
    else $error("read data without a read");
  a_rdata_pad: assert property (s_any_rd |=> hrdata[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  a_stat_rsvd: assert property (s_rd(A_STAT) |=> hrdata[3:0] == 4'h0)
    else $error("reserved status bits not zero");
  a_clear_wo: assert property (s_rd(A_ICLR) |=> hrdata == 32'h0)
    else $error("clear register read back data");
  a_oe_pair: assert property (mosi_oe_n == sck_oe_n)
    else $error("clock and data enables differ");
  a_no_contend: assert property (!miso_oe_n |-> sck_oe_n)
    else $error("slave and master drive at once");
  a_reset_quiet: assert property ($rose(hresetn) |-> sck_oe_n && miso_oe_n && !irq)
    else $error("pins driven straight after reset");
endmodule
bind spms_top spms_top_assertions #(.DIV_W(DIV_W)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .sck_oe_n(sck_oe_n), .mosi_oe_n(mosi_oe_n), .miso_oe_n(miso_oe_n), .irq(irq));

/* spms_slave_model.sv */
// behavioural spi slave at the master's far side
`timescale 1ns/10ps
module spms_slave_model (
  // pins
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  output logic            miso,
  // mode and data
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic [7:0] tx_byte,
  output logic [7:0]      rx_byte
);
  logic [7:0] sh = 8'h00;
  logic       bit_q = 1'b0;
  wire        lead = sck ^ cpol;
  initial rx_byte = 8'h00;
  // a released line shows the inverse of its last bit, never a held value
  assign miso = ss_n ? ~bit_q : bit_q;
  always @(negedge ss_n) begin
    sh = tx_byte;
    bit_q = tx_byte[7];
  end
  always @(posedge lead) if (!ss_n) begin
    if (cpha) bit_q = sh[7];
    else sh = {sh[6:0], mosi};
    rx_byte = sh;
  end
  always @(negedge lead) if (!ss_n) begin
    if (cpha) sh = {sh[6:0], mosi};
    else bit_q = sh[7];
    rx_byte = sh;
  end
endmodule

/* test_spi_master_slave_port.sv */
// self-checking bench for the spi master/slave port
`timescale 1ns/10ps
`include "spms_params.svh"
module test_spi_master_slave_port;
  localparam logic [31:0] A_CTRL = {22'h0, `SPMS_IDX_CTRL, 2'h0};
  localparam logic [31:0] A_STAT = {22'h0, `SPMS_IDX_STATUS, 2'h0};
  localparam logic [31:0] A_DATA = {22'h0, `SPMS_IDX_DATA, 2'h0};
  localparam logic [31:0] A_IEN  = {22'h0, `SPMS_IDX_IEN, 2'h0};
  localparam logic [31:0] A_ICLR = {22'h0, `SPMS_IDX_ICLR, 2'h0};
  typedef struct packed {
    logic [2:0] rate;
    logic       cpol;
    logic       cpha;
    logic [7:0] mtx;
    logic [7:0] stx;
  } spms_row_t;
  spms_row_t rows [7] = '{'{3'h0, 1'b0, 1'b0, 8'ha5, 8'h3c}, '{3'h1, 1'b0, 1'b1, 8'h81, 8'h7e},
    '{3'h2, 1'b1, 1'b0, 8'h00, 8'hff}, '{3'h3, 1'b1, 1'b1, 8'hff, 8'h01},
    '{3'h4, 1'b0, 1'b0, 8'h5a, 8'hc3}, '{3'h5, 1'b0, 1'b1, 8'h96, 8'h69},
    '{3'h6, 1'b1, 1'b0, 8'h12, 8'hed}};
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic        sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n, slv_miso;
  logic        tb_sck, tb_mosi, tb_ss_n, slv_ss_n, cpol, cpha, sck_q;
  logic [7:0]  slv_tx, slv_rx, rxm;
  int          err_count = 0, samples_checked = 0, edges = 0, gap = 0, last_gap = 0;
  int          cycles = 0, e0;
  wire         sck_w = !sck_oe_n ? sck_out : tb_sck;
  wire         mosi_w = !mosi_oe_n ? mosi_out : tb_mosi;
  wire         miso_w = !miso_oe_n ? miso_out : slv_miso;
  ////////////////////////////////////////
  spms_top DUT (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sck_in(sck_w),
    .sck_out(sck_out), .sck_oe_n(sck_oe_n), .mosi_in(mosi_w), .mosi_out(mosi_out),
    .mosi_oe_n(mosi_oe_n), .miso_in(miso_w), .miso_out(miso_out), .miso_oe_n(miso_oe_n),
    .ss_n_in(tb_ss_n), .irq(irq));
  spms_slave_model u_slave (.sck(sck_w), .mosi(mosi_w), .ss_n(slv_ss_n), .miso(slv_miso),
    .cpol(cpol), .cpha(cpha), .tx_byte(slv_tx), .rx_byte(slv_rx));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // counts serial clock edges and the spacing of the last two
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    sck_q <= sck_out;
    gap <= gap + 1;
    if (!sck_oe_n && sck_out !== sck_q) begin
      edges <= edges + 1;
      last_gap <= gap + 1;
      gap <= 0;
    end
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end
  ////////////////////////////////////////
  task automatic stop_test();
    if (err_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    for (n = 0; n < 50; n++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    for (n = 0; n < 50; n++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    rd = hrdata;
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  task automatic wait_irq();
    int n;
    for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge hclk);
    chk({31'h0, irq}, 32'h1);
  endtask
  // plays an outside master: cpha 1, cpol 0, msb first
  task automatic sbits(input logic [7:0] b, input int n);
    for (int k = 7; k > 7 - n; k--) begin
      tb_sck <= 1'b1;
      tb_mosi <= b[k];
      repeat (8) @(posedge hclk);
      rxm = {rxm[6:0], miso_w};
      tb_sck <= 1'b0;
      repeat (8) @(posedge hclk);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    {hresetn, hsel, htrans, haddr, hwrite, hwdata} = '0;
    {tb_sck, tb_mosi, cpol, cpha, slv_tx, sck_q} = '0;
    tb_ss_n = 1'b1;
    slv_ss_n = 1'b1;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(A_CTRL, 32'hffff_ffff, 32'h0);
    rchk(A_STAT, 32'hffff_ffff, 32'h0);
    rchk(32'h0000_0400, 32'hffff_ffff, 32'h0);
    bus(1'b1, A_IEN, 32'h80);
    foreach (rows[i]) begin
      cpol <= rows[i].cpol;
      cpha <= rows[i].cpha;
      slv_tx <= rows[i].stx;
      bus(1'b1, A_CTRL, {24'h0, rows[i].rate[2], 3'b101, rows[i].cpol, rows[i].cpha,
        rows[i].rate[1:0]});
      slv_ss_n <= 1'b0;
      bus(1'b1, A_DATA, {24'h0, rows[i].mtx});
      // counted after the load: a cpol change moves the idle clock once
      e0 = edges;
      wait_irq();
      // quiet window longer than two slowest half periods: no extra clocks
      repeat (260) @(posedge hclk);
      chk(edges - e0, 32'd16);
      chk(last_gap, 32'h1 << rows[i].rate);
      chk({24'h0, slv_rx}, {24'h0, rows[i].mtx});
      // the two fastest rates leave no margin for the input synchroniser
      if (rows[i].rate > 3'h1) rchk(A_DATA, 32'hff, {24'h0, rows[i].stx});
      bus(1'b1, A_ICLR, 32'h80);
      slv_ss_n <= 1'b1;
    end
    cpol <= 1'b0;
    bus(1'b1, A_CTRL, 32'hd2);
    slv_ss_n <= 1'b0;
    bus(1'b1, A_DATA, 32'h5a);
    rchk(A_DATA, 32'hff, {24'h0, rows[6].stx});
    bus(1'b1, A_DATA, 32'hc3);
    rchk(A_STAT, 32'h40, 32'h40);
    bus(1'b1, A_CTRL, 32'h92);
    repeat (2) @(posedge hclk);
    e0 = edges;
    repeat (300) @(posedge hclk);
    chk(edges - e0, 32'h0);
    chk({31'h0, sck_oe_n}, 32'h1);
    // rate code 111 has no generator: a started byte never clocks
    bus(1'b1, A_CTRL, 32'hd3);
    bus(1'b1, A_DATA, 32'h5a);
    e0 = edges;
    repeat (300) @(posedge hclk);
    chk(edges - e0, 32'h0);
    bus(1'b1, A_CTRL, 32'h00);
    slv_ss_n <= 1'b1;
    bus(1'b1, A_IEN, 32'h10);
    bus(1'b1, A_CTRL, 32'h50);
    tb_ss_n <= 1'b0;
    repeat (8) @(posedge hclk);
    rchk(A_STAT, 32'h10, 32'h10);
    chk({30'h0, irq, sck_oe_n}, 32'h3);
    bus(1'b1, A_IEN, 32'h0);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, A_IEN, 32'h10);
    bus(1'b1, A_CTRL, 32'h70);
    repeat (8) @(posedge hclk);
    rchk(A_STAT, 32'h10, 32'h10);
    bus(1'b1, A_ICLR, 32'h10);
    repeat (8) @(posedge hclk);
    rchk(A_STAT, 32'h10, 32'h0);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, A_CTRL, 32'h50);
    tb_ss_n <= 1'b1;
    repeat (8) @(posedge hclk);
    rchk(A_STAT, 32'h10, 32'h0);
    bus(1'b1, A_CTRL, 32'h44);
    repeat (6) @(posedge hclk);
    chk({31'h0, miso_oe_n}, 32'h1);
    tb_ss_n <= 1'b0;
    repeat (6) @(posedge hclk);
    chk({31'h0, miso_oe_n}, 32'h0);
    sbits(8'h00, 3);
    tb_ss_n <= 1'b1;
    repeat (8) @(posedge hclk);
    rchk(A_STAT, 32'h20, 32'h20);
    chk({31'h0, miso_oe_n}, 32'h1);
    bus(1'b1, A_CTRL, 32'h00);
    rchk(A_STAT, 32'h20, 32'h0);
    // cpha zero slave shows bit 7 as soon as it is selected
    bus(1'b1, A_CTRL, 32'h40);
    bus(1'b1, A_DATA, 32'h80);
    tb_ss_n <= 1'b0;
    repeat (6) @(posedge hclk);
    chk({30'h0, miso_oe_n, miso_w}, 32'h1);
    tb_ss_n <= 1'b1;
    bus(1'b1, A_CTRL, 32'h64);
    bus(1'b1, A_DATA, 32'h3c);
    repeat (6) @(posedge hclk);
    chk({31'h0, miso_oe_n}, 32'h0);
    sbits(8'h96, 8);
    chk({24'h0, rxm}, 32'h3c);
    repeat (8) @(posedge hclk);
    rchk(A_DATA, 32'hff, 32'h96);
    stop_test();
  end
endmodule
